/* File: src/lnr_axil_slave.v */
// AXI4-Lite slave front end with registered handshakes
`timescale 1ns/10ps
`include "lnr_defines.vh"
module lnr_axil_slave (
   input wire i_clk_sys,
   input wire i_rstn,
   input wire i_awvalid,
   input wire [`LNR_AW-1:0] i_awaddr,
   output reg o_awready,
   input wire i_wvalid,
   input wire [31:0] i_wdata,
   input wire [3:0] i_wstrb,
   output reg o_wready,
   output reg o_bvalid,
   output reg [1:0] o_bresp,
   input wire i_bready,
   input wire i_arvalid,
   input wire [`LNR_AW-1:0] i_araddr,
   output reg o_arready,
   output reg o_rvalid,
   output reg [31:0] o_rdata,
   output reg [1:0] o_rresp,
   input wire i_rready,
   output reg o_wr_en,
   output reg [`LNR_AW-1:0] o_wr_addr,
   output reg [31:0] o_wr_data,
   output reg [3:0] o_wr_strb,
   output reg [`LNR_AW-1:0] o_rd_addr,
   input wire [31:0] i_rd_data
);
   reg aw_hold_reg;
   reg w_hold_reg;
   reg ar_hold_reg;
   always @(posedge i_clk_sys) begin
      if (!i_rstn) begin
         o_awready <= 1'b1;
         o_wready <= 1'b1;
         o_bvalid <= 1'b0;
         o_bresp <= 2'h0;
         o_arready <= 1'b1;
         o_rvalid <= 1'b0;
         o_rdata <= `LNR_RST_WORD;
         o_rresp <= 2'h0;
         o_wr_en <= 1'b0;
         o_wr_addr <= {`LNR_AW{1'b0}};
         o_wr_data <= `LNR_RST_WORD;
         o_wr_strb <= 4'h0;
         o_rd_addr <= {`LNR_AW{1'b0}};
         aw_hold_reg <= 1'b0;
         w_hold_reg <= 1'b0;
         ar_hold_reg <= 1'b0;
      end else begin
         o_wr_en <= 1'b0;
         if (i_awvalid && o_awready) begin
            o_wr_addr <= i_awaddr;
            aw_hold_reg <= 1'b1;
            o_awready <= 1'b0;
         end
         if (i_wvalid && o_wready) begin
            o_wr_data <= i_wdata;
            o_wr_strb <= i_wstrb;
            w_hold_reg <= 1'b1;
            o_wready <= 1'b0;
         end
         // Write strobe fires once both halves are held
         if (aw_hold_reg && w_hold_reg && !o_bvalid) begin
            o_wr_en <= 1'b1;
            o_bvalid <= 1'b1;
            aw_hold_reg <= 1'b0;
            w_hold_reg <= 1'b0;
         end
         if (o_bvalid && i_bready) begin
            o_bvalid <= 1'b0;
            o_awready <= 1'b1;
            o_wready <= 1'b1;
         end
         if (i_arvalid && o_arready) begin
            o_rd_addr <= i_araddr;
            ar_hold_reg <= 1'b1;
            o_arready <= 1'b0;
         end
         if (ar_hold_reg) begin
            o_rdata <= i_rd_data;
            o_rvalid <= 1'b1;
            ar_hold_reg <= 1'b0;
         end
         if (o_rvalid && i_rready) begin
            o_rvalid <= 1'b0;
            o_arready <= 1'b1;
         end
      end
   end
endmodule // lnr_axil_slave

/* File: src/lnr_defines.vh */
// Register map, field positions and reset values of the LIN response block
`ifndef LNR_DEFINES_VH
`define LNR_DEFINES_VH
`define LNR_AW 8
`define LNR_OFS_GCR1 8'h00
`define LNR_OFS_FLAG 8'h04
`define LNR_OFS_INTEN 8'h08
`define LNR_OFS_FORMAT 8'h0C
`define LNR_OFS_ID 8'h10
`define LNR_OFS_MASK 8'h14
`define LNR_OFS_TD0 8'h18
`define LNR_OFS_TD1 8'h1C
`define LNR_OFS_RD0 8'h20
`define LNR_OFS_RD1 8'h24
`define LNR_GCR1_LEN_SRC 0
`define LNR_GCR1_PAR_EN 3
`define LNR_GCR1_CMP_SEL 5
`define LNR_GCR1_LIN 6
`define LNR_GCR1_MBUF 10
`define LNR_GCR1_CHECKSUM_TYPE_SELECT 12
`define LNR_GCR1_RX_EN 24
`define LNR_GCR1_TX_EN 25
`define LNR_FLAG_TRANSMIT_BUFFER_READY_FLAG 8
`define LNR_FLAG_RECEIVE_COMPLETE_FLAG 9
`define LNR_FLAG_TRANSMIT_DRAINED_FLAG 11
`define LNR_FLAG_TRANSMIT_IDENTIFIER_HIT_FLAG 13
`define LNR_FLAG_RECEIVE_IDENTIFIER_HIT_FLAG 14
`define LNR_FLAG_PE 24
`define LNR_FLAG_CE 27
`define LNR_INTEN_ID 13
`define LNR_FMT_LEN_LSB 16
`define LNR_ID_CAP_LSB 16
`define LNR_ID_TASK_LSB 8
`define LNR_MASK_RX_LSB 16
`define LNR_RST_WORD 32'h00000000
`define LNR_RST_BYTE 8'h00
`define LNR_CK_ALL 8'hFF
`define LNR_ID_RESERVED 6'h3C
`endif

/* File: src/lnr_id_filter.v */
// Masked identifier comparator
`timescale 1ns/10ps
module lnr_id_filter (
   input wire [7:0] i_id,
   input wire [7:0] i_ref,
   input wire [7:0] i_mask,
   input wire i_sel,
   output wire o_hit
);
   // Task-byte compare: full mask always hits; header-byte compare: full mask never hits
   assign o_hit = (!i_sel && (i_mask == 8'hFF)) ? 1'b0 :
                  (((i_id ^ i_ref) & ~i_mask) == 8'h00);
endmodule // lnr_id_filter

/* File: src/lnr_resp_top.v */
// LIN identifier filter, response buffers, counters and checksum
//
// Added by the designer: the placing of the registers and the AXI4-Lite interface to the registers.
`timescale 1ns/10ps
`include "lnr_defines.vh"
module lnr_resp_top (
   input wire i_clk_sys,
   input wire i_rstn,
   input wire i_axi_awvalid,
   input wire [`LNR_AW-1:0] i_axi_awaddr,
   output wire o_axi_awready,
   input wire i_axi_wvalid,
   input wire [31:0] i_axi_wdata,
   input wire [3:0] i_axi_wstrb,
   output wire o_axi_wready,
   output wire o_axi_bvalid,
   output wire [1:0] o_axi_bresp,
   input wire i_axi_bready,
   input wire i_axi_arvalid,
   input wire [`LNR_AW-1:0] i_axi_araddr,
   output wire o_axi_arready,
   output wire o_axi_rvalid,
   output wire [31:0] o_axi_rdata,
   output wire [1:0] o_axi_rresp,
   input wire i_axi_rready,
   input wire i_id_valid,
   input wire [7:0] i_header_identifier_byte,
   input wire i_rx_valid,
   input wire [7:0] i_rx_byte,
   input wire i_rx_frame_err,
   input wire i_rx_overrun,
   input wire i_tx_ready,
   input wire i_tx_idle,
   output reg o_tx_load,
   output reg [7:0] o_tx_byte,
   output reg o_id_int
);
   localparam PH_IDLE = 2'd0;
   localparam PH_DATA = 2'd1;
   localparam PH_CHECK = 2'd2;
   localparam PH_DRAIN = 2'd3;

   // Carry-wrapped 8-bit add: the carry out is added back into the sum
   function [7:0] ck_add;
      input [7:0] a;
      input [7:0] b;
      reg [8:0] s;
      begin
         s = {1'b0, a} + {1'b0, b};
         ck_add = s[7:0] + {7'd0, s[8]};
      end
   endfunction

   wire wr_en;
   wire [`LNR_AW-1:0] wr_addr;
   wire [31:0] wr_data;
   wire [3:0] wr_strb;
   wire [`LNR_AW-1:0] rd_addr;
   reg [31:0] rd_data;

   reg [31:0] gcr1_reg;
   reg [31:0] flag_reg;
   reg [31:0] flag_next;
   reg inten_id_reg;
   reg [2:0] fmt_len_reg;
   reg [7:0] hdr_id_reg;
   reg [7:0] task_id_reg;
   reg [7:0] cap_id_reg;
   reg [7:0] tx_mask_reg;
   reg [7:0] rx_mask_reg;
   reg [2:0] cmp_reg;
   reg [7:0] td [0:7];
   reg [7:0] rd [0:7];

   reg rx_act_reg;
   reg rx_chk_reg;
   reg rx_err_reg;
   reg [2:0] rx_cnt_reg;
   reg [7:0] rx_sum_reg;
   reg [1:0] tx_ph_reg;
   reg [2:0] tx_cnt_reg;
   reg [7:0] tx_sum_reg;
   reg td0_full_reg;

   lnr_axil_slave u_bus (
      .i_clk_sys(i_clk_sys),
      .i_rstn(i_rstn),
      .i_awvalid(i_axi_awvalid),
      .i_awaddr(i_axi_awaddr),
      .o_awready(o_axi_awready),
      .i_wvalid(i_axi_wvalid),
      .i_wdata(i_axi_wdata),
      .i_wstrb(i_axi_wstrb),
      .o_wready(o_axi_wready),
      .o_bvalid(o_axi_bvalid),
      .o_bresp(o_axi_bresp),
      .i_bready(i_axi_bready),
      .i_arvalid(i_axi_arvalid),
      .i_araddr(i_axi_araddr),
      .o_arready(o_axi_arready),
      .o_rvalid(o_axi_rvalid),
      .o_rdata(o_axi_rdata),
      .o_rresp(o_axi_rresp),
      .i_rready(i_axi_rready),
      .o_wr_en(wr_en),
      .o_wr_addr(wr_addr),
      .o_wr_data(wr_data),
      .o_wr_strb(wr_strb),
      .o_rd_addr(rd_addr),
      .i_rd_data(rd_data)
   );

   wire mbuf = gcr1_reg[`LNR_GCR1_MBUF];
   wire lin = gcr1_reg[`LNR_GCR1_LIN];
   wire cmp_sel = gcr1_reg[`LNR_GCR1_CMP_SEL];
   wire [7:0] ref_id = cmp_sel ? task_id_reg : hdr_id_reg;

   // Parity of the incoming identifier
   wire par_p0 = i_header_identifier_byte[0] ^ i_header_identifier_byte[1] ^ i_header_identifier_byte[2] ^ i_header_identifier_byte[4];
   wire par_p1 = ~(i_header_identifier_byte[1] ^ i_header_identifier_byte[3] ^ i_header_identifier_byte[4] ^ i_header_identifier_byte[5]);
   wire par_err = gcr1_reg[`LNR_GCR1_PAR_EN] && (i_header_identifier_byte[7:6] != {par_p1, par_p0});

   wire rx_match;
   wire tx_match;
   lnr_id_filter u_rx_filt (
      .i_id(i_header_identifier_byte),
      .i_ref(ref_id),
      .i_mask(rx_mask_reg),
      .i_sel(cmp_sel),
      .o_hit(rx_match)
   );
   lnr_id_filter u_tx_filt (
      .i_id(i_header_identifier_byte),
      .i_ref(ref_id),
      .i_mask(tx_mask_reg),
      .i_sel(cmp_sel),
      .o_hit(tx_match)
   );
   wire rx_hit = rx_match && !par_err && gcr1_reg[`LNR_GCR1_RX_EN];
   wire tx_hit = tx_match && !par_err && gcr1_reg[`LNR_GCR1_TX_EN];

   // Enhanced sum includes the identifier; reserved identifiers stay classic
   wire enh_hdr = gcr1_reg[`LNR_GCR1_CHECKSUM_TYPE_SELECT] && (i_header_identifier_byte[5:0] < `LNR_ID_RESERVED);
   wire enh_cap = gcr1_reg[`LNR_GCR1_CHECKSUM_TYPE_SELECT] && (cap_id_reg[5:0] < `LNR_ID_RESERVED);

   // Byte count minus one: identifier bits 5:4 give 2, 2, 4 or 8 bytes
   wire [2:0] id_len = cap_id_reg[5] ? (cap_id_reg[4] ? 3'd7 : 3'd3) : 3'd1;
   wire [2:0] cmp_next = gcr1_reg[`LNR_GCR1_LEN_SRC] ? fmt_len_reg : id_len;

   wire wr_gcr1 = wr_en && (wr_addr == `LNR_OFS_GCR1);
   wire wr_flag = wr_en && (wr_addr == `LNR_OFS_FLAG);
   wire wr_td0 = wr_en && (wr_addr == `LNR_OFS_TD0);
   wire wr_td1 = wr_en && (wr_addr == `LNR_OFS_TD1);
   wire td0_top_wr = wr_td0 && wr_strb[3];

   wire rx_take = i_rx_valid && (lin ? rx_act_reg : mbuf);
   wire rx_data = rx_take && !rx_chk_reg;
   wire rx_last = rx_data && (rx_cnt_reg == cmp_reg);
   wire [7:0] rx_sum_new = ck_add(rx_sum_reg, i_rx_byte);
   wire rx_chk_ok = (rx_sum_new == `LNR_CK_ALL) && !rx_err_reg && !i_rx_frame_err
                    && !i_rx_overrun;
   wire rx_done = rx_take && rx_chk_reg;

   wire tx_free = i_tx_ready && !o_tx_load;
   wire tx_data = (tx_ph_reg == PH_DATA) && tx_free && (mbuf || td0_full_reg);
   wire tx_check = (tx_ph_reg == PH_CHECK) && tx_free;
   wire tx_last = tx_data && (tx_cnt_reg == cmp_reg);
   wire [7:0] tx_src = mbuf ? td[tx_cnt_reg] : td[0];
   wire tx_drained = i_tx_idle && !o_tx_load && !td0_full_reg
                     && (((tx_ph_reg == PH_DATA) && !mbuf) || (tx_ph_reg == PH_DRAIN));

   // Flag set and clear; a set in the same cycle as a clear wins
   reg [31:0] flag_set;
   reg [31:0] flag_clr;
   always @* begin
      flag_set = 32'h00000000;
      flag_clr = wr_flag ? wr_data : 32'h00000000;
      if (i_id_valid) begin
         flag_set[`LNR_FLAG_RECEIVE_IDENTIFIER_HIT_FLAG] = rx_hit;
         flag_set[`LNR_FLAG_TRANSMIT_IDENTIFIER_HIT_FLAG] = tx_hit;
         flag_set[`LNR_FLAG_PE] = par_err;
      end
      if (rx_done && lin) begin
         flag_set[`LNR_FLAG_RECEIVE_COMPLETE_FLAG] = rx_chk_ok;
         flag_set[`LNR_FLAG_CE] = !rx_chk_ok;
      end
      if (rx_last && !lin) begin
         flag_set[`LNR_FLAG_RECEIVE_COMPLETE_FLAG] = 1'b1;
      end
      if ((tx_data && !mbuf) || tx_check) begin
         flag_set[`LNR_FLAG_TRANSMIT_BUFFER_READY_FLAG] = 1'b1;
      end
      if (tx_drained) begin
         flag_set[`LNR_FLAG_TRANSMIT_DRAINED_FLAG] = 1'b1;
      end
      // Refilling byte zero means the host has consumed the ready indication
      if (td0_top_wr) begin
         flag_clr[`LNR_FLAG_TRANSMIT_BUFFER_READY_FLAG] = 1'b1;
         flag_clr[`LNR_FLAG_TRANSMIT_DRAINED_FLAG] = 1'b1;
      end
      flag_next = (flag_reg & ~flag_clr) | flag_set;
   end

   // Transmit and receive byte buffers, one write port per entry
   genvar g;
   generate
      for (g = 0; g < 8; g = g + 1) begin : g_buf
         wire td_we = (g < 4) ? (wr_td0 && wr_strb[3 - (g % 4)])
                              : (wr_td1 && wr_strb[3 - (g % 4)]);
         always @(posedge i_clk_sys) begin
            if (!i_rstn) begin
               td[g] <= `LNR_RST_BYTE;
               rd[g] <= `LNR_RST_BYTE;
            end else begin
               if (td_we) begin
                  td[g] <= wr_data[8 * (3 - (g % 4)) +: 8];
               end
               if (rx_data && ((mbuf ? rx_cnt_reg : 3'd0) == g)) begin
                  rd[g] <= i_rx_byte;
               end
            end
         end
      end
   endgenerate

   always @(posedge i_clk_sys) begin
      if (!i_rstn) begin
         gcr1_reg <= `LNR_RST_WORD;
         flag_reg <= `LNR_RST_WORD;
         inten_id_reg <= 1'b0;
         fmt_len_reg <= 3'd0;
         hdr_id_reg <= `LNR_RST_BYTE;
         task_id_reg <= `LNR_RST_BYTE;
         cap_id_reg <= `LNR_RST_BYTE;
         tx_mask_reg <= `LNR_RST_BYTE;
         rx_mask_reg <= `LNR_RST_BYTE;
         cmp_reg <= 3'd0;
         o_id_int <= 1'b0;
      end else begin
         flag_reg <= flag_next;
         cmp_reg <= cmp_next;
         o_id_int <= inten_id_reg
                     && (flag_reg[`LNR_FLAG_RECEIVE_IDENTIFIER_HIT_FLAG] || flag_reg[`LNR_FLAG_TRANSMIT_IDENTIFIER_HIT_FLAG]);
         if (wr_gcr1) begin
            gcr1_reg <= wr_data;
         end
         if (wr_en && (wr_addr == `LNR_OFS_INTEN)) begin
            inten_id_reg <= wr_data[`LNR_INTEN_ID];
         end
         if (wr_en && (wr_addr == `LNR_OFS_FORMAT)) begin
            fmt_len_reg <= wr_data[`LNR_FMT_LEN_LSB +: 3];
         end
         if (wr_en && (wr_addr == `LNR_OFS_ID)) begin
            hdr_id_reg <= wr_data[7:0];
            task_id_reg <= wr_data[`LNR_ID_TASK_LSB +: 8];
         end
         if (wr_en && (wr_addr == `LNR_OFS_MASK)) begin
            tx_mask_reg <= wr_data[7:0];
            rx_mask_reg <= wr_data[`LNR_MASK_RX_LSB +: 8];
         end
         if (i_id_valid) begin
            cap_id_reg <= i_header_identifier_byte;
         end
      end
   end

   // Receive side: data bytes, then in LIN mode the checkbyte
   always @(posedge i_clk_sys) begin
      if (!i_rstn) begin
         rx_act_reg <= 1'b0;
         rx_chk_reg <= 1'b0;
         rx_err_reg <= 1'b0;
         rx_cnt_reg <= 3'd0;
         rx_sum_reg <= `LNR_RST_BYTE;
      end else if (i_id_valid && lin) begin
         rx_act_reg <= rx_hit;
         rx_chk_reg <= 1'b0;
         rx_err_reg <= 1'b0;
         rx_cnt_reg <= 3'd0;
         rx_sum_reg <= enh_hdr ? i_header_identifier_byte : `LNR_RST_BYTE;
      end else begin
         // Errors arriving mid-frame must still spoil the acknowledge
         if (rx_act_reg && (i_rx_frame_err || i_rx_overrun)) begin
            rx_err_reg <= 1'b1;
         end
         if (rx_done) begin
            rx_act_reg <= 1'b0;
            rx_chk_reg <= 1'b0;
         end else if (rx_data) begin
            rx_sum_reg <= rx_sum_new;
            if (rx_last) begin
               rx_chk_reg <= lin;
               rx_cnt_reg <= 3'd0;
            end else begin
               rx_cnt_reg <= rx_cnt_reg + 3'd1;
            end
         end
      end
   end

   // Transmit side: data bytes, then checkbyte, then wait for the line to drain
   always @(posedge i_clk_sys) begin
      if (!i_rstn) begin
         tx_ph_reg <= PH_IDLE;
         tx_cnt_reg <= 3'd0;
         tx_sum_reg <= `LNR_RST_BYTE;
         td0_full_reg <= 1'b0;
         o_tx_load <= 1'b0;
         o_tx_byte <= `LNR_RST_BYTE;
      end else begin
         o_tx_load <= 1'b0;
         if (tx_data) begin
            td0_full_reg <= 1'b0;
         end
         // A write landing with a load keeps the new byte pending
         if (td0_top_wr) begin
            td0_full_reg <= 1'b1;
         end
         case (tx_ph_reg)
            PH_IDLE: begin
               if (td0_top_wr) begin
                  tx_ph_reg <= PH_DATA;
                  tx_cnt_reg <= 3'd0;
                  tx_sum_reg <= enh_cap ? cap_id_reg : `LNR_RST_BYTE;
               end
            end
            PH_DATA: begin
               if (tx_data) begin
                  o_tx_load <= 1'b1;
                  o_tx_byte <= tx_src;
                  tx_sum_reg <= ck_add(tx_sum_reg, tx_src);
                  if (tx_last) begin
                     tx_ph_reg <= PH_CHECK;
                  end else begin
                     tx_cnt_reg <= tx_cnt_reg + 3'd1;
                  end
               end
            end
            PH_CHECK: begin
               if (tx_check) begin
                  o_tx_load <= 1'b1;
                  o_tx_byte <= ~tx_sum_reg;
                  tx_ph_reg <= PH_DRAIN;
               end
            end
            PH_DRAIN: begin
               if (tx_drained) begin
                  tx_ph_reg <= PH_IDLE;
               end
            end
            default: begin
               tx_ph_reg <= PH_IDLE;
            end
         endcase
      end
   end

   // Register read mux; unmapped addresses read as zero
   always @* begin
      case (rd_addr)
         `LNR_OFS_GCR1: rd_data = gcr1_reg;
         `LNR_OFS_FLAG: rd_data = flag_reg;
         `LNR_OFS_INTEN: rd_data = {18'd0, inten_id_reg, 13'd0};
         `LNR_OFS_FORMAT: rd_data = {13'd0, fmt_len_reg, 16'd0};
         `LNR_OFS_ID: rd_data = {8'd0, cap_id_reg, task_id_reg, hdr_id_reg};
         `LNR_OFS_MASK: rd_data = {8'd0, rx_mask_reg, 8'd0, tx_mask_reg};
         `LNR_OFS_TD0: rd_data = {td[0], td[1], td[2], td[3]};
         `LNR_OFS_TD1: rd_data = {td[4], td[5], td[6], td[7]};
         `LNR_OFS_RD0: rd_data = {rd[0], rd[1], rd[2], rd[3]};
         `LNR_OFS_RD1: rd_data = {rd[4], rd[5], rd[6], rd[7]};
         default: rd_data = 32'h00000000;
      endcase
   end
endmodule // lnr_resp_top

/* File: verification/lnr_node_model.sv */
// Far LIN node: header and response source, transmit shifter sink
`timescale 1ns/10ps
module lnr_node_model (
   input wire logic i_clk_sys,
   input wire logic i_tx_load,
   input wire logic [7:0] i_tx_byte,
   output logic o_id_valid,
   output logic [7:0] o_header_identifier_byte,
   output logic o_rx_valid,
   output logic [7:0] o_rx_byte,
   output logic o_rx_frame_err,
   output logic o_tx_ready,
   output logic o_tx_idle
);
   int gap = 4;
   int cnt = 0;
   logic [7:0] q[$];
   initial begin
      o_id_valid = 1'h0;
      o_header_identifier_byte = 8'h5A;
      o_rx_valid = 1'h0;
      o_rx_byte = 8'hA5;
      o_rx_frame_err = 1'h0;
   end
   // One shift stage only, so ready and idle coincide; gap sets the line speed
   always @(posedge i_clk_sys) begin
      if (i_tx_load) begin
         q.push_back(i_tx_byte);
         cnt <= gap;
      end else if (cnt > 0) begin
         cnt <= cnt - 1;
      end
   end
   assign o_tx_ready = cnt == 0 && !i_tx_load;
   assign o_tx_idle = o_tx_ready;
   // Idle data lines show the inverse so a stale byte is never mistaken
   task hdr(input [7:0] b);
      @(posedge i_clk_sys);
      o_header_identifier_byte <= b;
      o_id_valid <= 1'h1;
      @(posedge i_clk_sys);
      o_id_valid <= 1'h0;
      o_header_identifier_byte <= ~b;
   endtask
   task dat(input [7:0] b, input e);
      @(posedge i_clk_sys);
      o_rx_byte <= b;
      o_rx_valid <= 1'h1;
      o_rx_frame_err <= e;
      @(posedge i_clk_sys);
      o_rx_valid <= 1'h0;
      o_rx_frame_err <= 1'h0;
      o_rx_byte <= ~b;
   endtask
endmodule // lnr_node_model

/* File: verification/lnr_resp_properties.sv */
// Bus handshake, transmit handshake and interrupt cause checks for the LIN response block
`timescale 1ns/10ps
module lnr_resp_properties (
   input wire logic i_clk_sys,
   input wire logic i_rstn,
   input wire logic i_axi_awvalid,
   input wire logic o_axi_awready,
   input wire logic i_axi_wvalid,
   input wire logic o_axi_wready,
   input wire logic o_axi_bvalid,
   input wire logic [1:0] o_axi_bresp,
   input wire logic i_axi_bready,
   input wire logic i_axi_arvalid,
   input wire logic o_axi_arready,
   input wire logic o_axi_rvalid,
   input wire logic [1:0] o_axi_rresp,
   input wire logic i_axi_rready,
   input wire logic i_id_valid,
   input wire logic i_tx_ready,
   input wire logic o_tx_load,
   input wire logic [7:0] o_tx_byte,
   input wire logic o_id_int
);
   default clocking @(posedge i_clk_sys); endclocking
   default disable iff (!i_rstn);
   a_write_answer: assert property (i_axi_awvalid && o_axi_awready && i_axi_wvalid &&
      o_axi_wready |=> !o_axi_awready ##1 o_axi_bvalid) else $error("write answer late");
   a_read_answer: assert property (i_axi_arvalid && o_axi_arready |=>
      !o_axi_arready ##1 o_axi_rvalid) else $error("read answer late");
   a_bresp_okay: assert property (o_axi_bvalid |-> o_axi_bresp == 2'h0 && !o_axi_wready)
      else $error("bad write response");
   a_rresp_okay: assert property (o_axi_rvalid |-> o_axi_rresp == 2'h0 && !o_axi_arready)
      else $error("bad read response");
   a_bvalid_taken: assert property (o_axi_bvalid && i_axi_bready |=> !o_axi_bvalid)
      else $error("write response repeated");
   a_rvalid_taken: assert property (o_axi_rvalid && i_axi_rready |=> !o_axi_rvalid)
      else $error("read response repeated");
   a_load_single: assert property (o_tx_load |=> !o_tx_load) else $error("long load");
   a_load_ready: assert property (o_tx_load |-> $past(i_tx_ready)) else $error("load busy");
   a_byte_hold: assert property (!o_tx_load |-> $stable(o_tx_byte)) else $error("byte moved");
   a_int_cause: assert property ($rose(o_id_int) |-> $past(i_id_valid, 2) ||
      $past(i_id_valid, 3) || $past(o_axi_bvalid) || $past(o_axi_bvalid, 2))
      else $error("interrupt without cause");
endmodule // lnr_resp_properties

/* File: verification/test_lnr_resp_top.sv */
// Self-checking bench for the LIN response block
`timescale 1ns/10ps
`include "lnr_defines.vh"
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin errors++; \
   $display("unexpected at %0t got %h exp %h", $time, g, e); end end
module test_lnr_resp_top;
   logic clk, rstn, awv, wv, arv, sel, par, re, te, ie, pe;
   logic [7:0] awa, ara, id, hid, tid, mr, mt, ck;
   logic [31:0] wd, v, w;
   logic [7:0] d[8];
   wire awr, wrd, bv, arr, rv, ld, idv, rxv, fe, txr, txi, iint;
   wire [31:0] rd;
   wire [7:0] txb, idb, rxb;
   int errors = 0;
   int check_count = 0;
   int k, i, n, t, bd;
   lnr_resp_top u_lnr_resp_top (.i_clk_sys(clk), .i_rstn(rstn), .i_axi_awvalid(awv),
      .i_axi_awaddr(awa), .o_axi_awready(awr), .i_axi_wvalid(wv), .i_axi_wdata(wd),
      .i_axi_wstrb(4'hF), .o_axi_wready(wrd), .o_axi_bvalid(bv), .o_axi_bresp(),
      .i_axi_bready(1'h1), .i_axi_arvalid(arv), .i_axi_araddr(ara), .o_axi_arready(arr),
      .o_axi_rvalid(rv), .o_axi_rdata(rd), .o_axi_rresp(), .i_axi_rready(1'h1),
      .i_id_valid(idv), .i_header_identifier_byte(idb), .i_rx_valid(rxv), .i_rx_byte(rxb),
      .i_rx_frame_err(fe), .i_rx_overrun(1'h0), .i_tx_ready(txr), .i_tx_idle(txi),
      .o_tx_load(ld), .o_tx_byte(txb), .o_id_int(iint));
   lnr_node_model u_lnr_node_model (.i_clk_sys(clk), .i_tx_load(ld), .i_tx_byte(txb),
      .o_id_valid(idv), .o_header_identifier_byte(idb), .o_rx_valid(rxv), .o_rx_byte(rxb),
      .o_rx_frame_err(fe), .o_tx_ready(txr), .o_tx_idle(txi));
   function automatic [7:0] pid(input [5:0] x);
      pid = {~(x[1] ^ x[3] ^ x[4] ^ x[5]), x[0] ^ x[1] ^ x[2] ^ x[4], x};
   endfunction
   function automatic [7:0] cadd(input [7:0] a, input [7:0] b);
      logic [8:0] s;
      s = a + b;
      cadd = s[7:0] + s[8];
   endfunction
   function automatic logic hit(input [7:0] a, input [7:0] r, input [7:0] m, input s);
      hit = (s || m != 8'hFF) && ((a ^ r) & ~m) == 8'h00;
   endfunction
   task wreg(input [7:0] a, input [31:0] x);
      awa <= a;
      wd <= x;
      awv <= 1'h1;
      wv <= 1'h1;
      t = 0;
      do begin
         @(posedge clk);
         if (awr) awv <= 1'h0;
         if (wrd) wv <= 1'h0;
      end while (!bv && ++t < 99);
      // A bus that never answers counts as a mismatch
      if (t >= 99) errors++;
   endtask
   task rreg(input [7:0] a);
      ara <= a;
      arv <= 1'h1;
      t = 0;
      do begin
         @(posedge clk);
         if (arr) arv <= 1'h0;
      end while (!rv && ++t < 99);
      if (t >= 99) errors++;
      v = rd;
   endtask
   task wdone(input int m);
      for (t = 0; t < 4000 && !(u_lnr_node_model.q.size() >= m && txi); t++) @(posedge clk);
      `CHK(t < 4000, 1'h1)
   endtask
   task close_out;
      $display("checks %0d mismatches %0d", check_count, errors);
      if (errors == 0 && check_count > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask
   initial begin
      clk = 1'h0;
      forever #4 clk = ~clk;
   end
   // Expected run is well under 20k cycles
   initial begin
      #400000;
      errors++;
      close_out;
   end
   initial begin
      {rstn, awv, wv, arv, awa, ara, wd} = '0;
      k = $urandom(67);
      repeat (12) @(posedge clk);
      rstn <= 1'h1;
      @(posedge clk);
      wreg(`LNR_OFS_MASK, 32'h00A5003C);
      rreg(`LNR_OFS_MASK);
      `CHK(v, 32'h00A5003C)
      wreg(`LNR_OFS_ID, 32'hFFFFFFFF);
      rreg(`LNR_OFS_ID);
      `CHK(v, 32'h0000FFFF)
      wreg(8'h30, 32'h12345678);
      rreg(8'h30);
      `CHK(v, 32'h00000000)
      $display("test registers done");
      for (k = 0; k < 48; k++) begin
         id = pid(6'($urandom));
         hid = ($urandom % 2) ? 8'($urandom) : id;
         tid = id;
         mr = ($urandom % 2) ? 8'h00 : 8'($urandom);
         mt = ($urandom % 2) ? 8'h00 : 8'($urandom);
         {sel, par, re, te, ie} = 5'($urandom);
         if (k < 2) {mr, mt, sel} = {16'hFFFF, 1'(k)};
         if ($urandom % 3 == 0) id = $urandom;
         wreg(`LNR_OFS_GCR1, {6'h0, te, re, 17'h0, 1'h1, sel, 1'h0, par, 3'h0});
         wreg(`LNR_OFS_ID, {16'h0, tid, hid});
         wreg(`LNR_OFS_MASK, {8'h0, mr, 8'h0, mt});
         wreg(`LNR_OFS_INTEN, 32'(ie) << 13);
         wreg(`LNR_OFS_FLAG, 32'hFFFFFFFF);
         u_lnr_node_model.hdr(id);
         repeat (2) @(posedge clk);
         pe = par && id != pid(id[5:0]);
         rreg(`LNR_OFS_FLAG);
         `CHK(v[14], re && !pe && hit(id, sel ? tid : hid, mr, sel))
         `CHK(v[13], te && !pe && hit(id, sel ? tid : hid, mt, sel))
         `CHK(v[24], pe)
         `CHK(iint, ie && (v[13] || v[14]))
         rreg(`LNR_OFS_ID);
         `CHK(v[23:16], id)
      end
      $display("test filter done");
      for (k = 0; k < 12; k++) begin
         id = pid(k == 0 ? 6'h3C : 6'($urandom));
         {sel, te} = 2'($urandom);
         n = $urandom % 8;
         bd = $urandom % 4;
         wreg(`LNR_OFS_GCR1, {7'h0, 1'h1, 11'h0, te, 2'h1, 3'h0, 4'h9, 2'h0, sel});
         wreg(`LNR_OFS_FORMAT, 32'(n) << 16);
         wreg(`LNR_OFS_ID, {24'h0, id});
         wreg(`LNR_OFS_MASK, 32'h0);
         wreg(`LNR_OFS_FLAG, 32'hFFFFFFFF);
         n = sel ? n + 1 : (id[5] ? (id[4] ? 8 : 4) : 2);
         ck = (te && id[5:0] < 6'h3C) ? id : 8'h00;
         u_lnr_node_model.hdr(id);
         for (i = 0; i < n; i++) begin
            d[i] = $urandom;
            ck = cadd(ck, d[i]);
            u_lnr_node_model.dat(d[i], bd == 2 && i == 0);
         end
         u_lnr_node_model.dat(bd == 1 ? ck : ~ck, 1'h0);
         repeat (2) @(posedge clk);
         rreg(`LNR_OFS_FLAG);
         `CHK(v[9], bd != 1 && bd != 2)
         // A framing error also spoils the checkbyte acknowledge
         `CHK(v[27], bd == 1 || bd == 2)
         rreg(`LNR_OFS_RD0);
         w = v;
         rreg(`LNR_OFS_RD1);
         for (i = 0; i < n && bd != 2; i++) `CHK(8'({w, v} >> (56 - 8 * i)), d[i])
      end
      $display("test receive done");
      for (k = 0; k < 6; k++) begin
         sel = k < 4;
         n = k == 0 ? 0 : (k == 1 ? 7 : $urandom % (sel ? 8 : 3));
         u_lnr_node_model.gap = 1 + $urandom % 12;
         u_lnr_node_model.q.delete();
         wreg(`LNR_OFS_GCR1, {21'h0, sel, 4'h1, 6'h1});
         wreg(`LNR_OFS_FORMAT, 32'(n) << 16);
         wreg(`LNR_OFS_FLAG, 32'hFFFFFFFF);
         ck = 8'h00;
         for (i = 0; i < 8; i++) d[i] = $urandom;
         for (i = 0; i <= n; i++) ck = cadd(ck, d[i]);
         if (sel) begin
            wreg(`LNR_OFS_TD1, {d[4], d[5], d[6], d[7]});
            wreg(`LNR_OFS_TD0, {d[0], d[1], d[2], d[3]});
         end else for (i = 0; i <= n; i++) begin
            wreg(`LNR_OFS_TD0, {d[i], 24'h0});
            wdone(i + 1);
            rreg(`LNR_OFS_FLAG);
            if (i < n) `CHK(v[8], 1'h1)
            if (i < n) `CHK(v[11], 1'h1)
         end
         wdone(n + 2);
         for (i = 0; i <= n; i++) `CHK(u_lnr_node_model.q[i], d[i])
         `CHK(u_lnr_node_model.q[n + 1], ~ck)
         rreg(`LNR_OFS_FLAG);
         `CHK(v[8], 1'h1)
         `CHK(v[11], 1'h1)
      end
      $display("test transmit done");
      close_out;
   end
endmodule // test_lnr_resp_top
bind lnr_resp_top lnr_resp_properties u_lnr_resp_properties (.i_clk_sys(i_clk_sys),
   .i_rstn(i_rstn), .i_axi_awvalid(i_axi_awvalid), .o_axi_awready(o_axi_awready),
   .i_axi_wvalid(i_axi_wvalid), .o_axi_wready(o_axi_wready), .o_axi_bvalid(o_axi_bvalid),
   .o_axi_bresp(o_axi_bresp), .i_axi_bready(i_axi_bready), .i_axi_arvalid(i_axi_arvalid),
   .o_axi_arready(o_axi_arready), .o_axi_rvalid(o_axi_rvalid), .o_axi_rresp(o_axi_rresp),
   .i_axi_rready(i_axi_rready), .i_id_valid(i_id_valid), .i_tx_ready(i_tx_ready),
   .o_tx_load(o_tx_load), .o_tx_byte(o_tx_byte), .o_id_int(o_id_int));
